// >>> design/mic_params.svh
// constants for the interrupt controller: offsets, bit positions, reset values
`ifndef MIC_PARAMS_SVH
`define MIC_PARAMS_SVH

// register byte offsets on the bus
`define MIC_OFF_CTRL        8'h00
`define MIC_OFF_FLAG_A      8'h04
`define MIC_OFF_FLAG_B      8'h08
`define MIC_OFF_EN_A        8'h0C
`define MIC_OFF_EN_B        8'h10
`define MIC_OFF_OPTION      8'h14
`define MIC_OFF_PORT_EN     8'h18
`define MIC_OFF_STATUS      8'h1C

// control register bit positions
`define MIC_BIT_GLOBAL_EN   7
`define MIC_BIT_GROUP_EN    6
`define MIC_BIT_T0IE        5
`define MIC_BIT_EXTIE       4
`define MIC_BIT_PCIE        3
`define MIC_BIT_T0F         2
`define MIC_BIT_EXTF        1
`define MIC_BIT_PCF         0
`define MIC_CTRL_EN_HI      5
`define MIC_CTRL_EN_LO      3
`define MIC_CTRL_FLAG_HI    2
`define MIC_CTRL_FLAG_LO    0

// option register edge select and status bit positions
`define MIC_BIT_EDGE_SEL    6
`define MIC_BIT_TIMEOUT     4
`define MIC_BIT_PWRDOWN     3

// implemented bit masks; unimplemented bits read as zero
`define MIC_MASK_CTRL_FLAG  8'h07
`define MIC_MASK_FLAG_A     8'h7F
`define MIC_MASK_FLAG_B     8'hFD

// reset values
`define MIC_RST_BYTE        8'h00
`define MIC_RST_EDGE_SEL    1'b1
`define MIC_RST_TIMEOUT     1'b1
`define MIC_RST_PWRDOWN     1'b1

// interrupt vector and timer rollover values
`define MIC_VECTOR          13'h0004
`define MIC_TMR_MAX         8'hFF
`define MIC_TMR_ZERO        8'h00
`define MIC_PC_ZERO         13'h0000
`define MIC_WB_ZERO         32'h0000_0000

`endif

// >>> design/mic_pkg.sv
// types shared by the interrupt controller and its neighbours
package mic_pkg;

  // sleep and wake sequencing of the core
  typedef enum logic [1:0] {
    MIC_RUN,
    MIC_ASLEEP,
    MIC_WAKE
  } mic_wake_state_t;

  // what the core tells the controller each instruction cycle
  typedef struct packed {
    logic        ret_irq;   // return_from_irq_instr executed this cycle
    logic        sleep;     // core is in sleep
    logic [12:0] pc;        // address of the next instruction
  } mic_core_in_t;

  // what the controller tells the core
  typedef struct packed {
    logic        push;      // push ret_addr onto the hardware stack
    logic        pc_load;   // load vector into the program counter
    logic        wake;      // leave sleep and execute pc + 1
    logic [12:0] ret_addr;
    logic [12:0] vector;
  } mic_core_out_t;

endpackage : mic_pkg

// >>> design/mic_pin_sync.sv
// two-stage synchroniser for the external pin and port b, with a history stage
`timescale 1ns/1ns
`default_nettype none

module mic_pin_sync (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [8:0] pins_i,
  output logic      [8:0] sync_o,
  output logic      [8:0] prev_o
);

  logic [8:0] meta;

  // first stage feeds only the second; prev lets the caller see edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // load the pin level, not zero, so a pin idling high shows no edge after reset
      meta   <= pins_i;
      sync_o <= pins_i;
      prev_o <= pins_i;
    end else begin
      meta   <= pins_i;
      sync_o <= meta;
      prev_o <= sync_o;
    end
  end

endmodule : mic_pin_sync

`default_nettype wire

// >>> design/mic_flag_bank.sv
// one byte of sticky request flags, hardware set wins over software write
`timescale 1ns/1ns
`default_nettype none
`include "mic_params.svh"

module mic_flag_bank #(
  parameter logic [7:0] IMPL_MASK = 8'hFF
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] set_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wr_data_i,
  output logic      [7:0] flags_o
);

  logic [7:0] next_flags;

  // events set regardless of any enable; set ORs over the write value
  always_comb begin
    next_flags = ((wr_i ? wr_data_i : flags_o) | set_i) & IMPL_MASK;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_o <= `MIC_RST_BYTE;
    end else begin
      flags_o <= next_flags;
    end
  end

endmodule : mic_flag_bank

`default_nettype wire

// >>> design/mic_irq_ctrl.sv
// interrupt controller top: wishbone registers, masking, vectoring and wake
//
// Notes on behaviour
// - control bit 7 global enable passes unmasked requests; clear blocks all.
// - every reset clears the global enable.
// - each source has its own enable bit; a clear enable masks it.
// - return from interrupt sets the global enable again.
// - taking an interrupt clears enable, pushes return address, loads 0004h.
// - pin and port-change events reach the vector in three or four cycles.
// - flags are set by events whatever the enables say, except the per-pin port b change enables.
// - a request due when enable is being cleared is held pending.
// - control register holds pin, port-change and timer-zero flags.
// - flag register a: converter, serial rx/tx, timers, sync serial, capture one.
// - flag register b: clock monitor, comparators, eeprom, low-power wake, capture two.
// - interrupt wake executes pc + 1, then vectors if global enable set.
// - an interrupt wake is always shown by a set flag bit.
// - interrupt wake leaves status timeout bit set and power-down bit clear.
// - external pin flag sets on rising or falling edge per edge select.
// - timer-zero flag sets when the count rolls from FFh to zero.
// - a change on an enabled port b pin sets the port-change flag.
`timescale 1ns/1ns
`default_nettype none
`include "mic_params.svh"

module mic_irq_ctrl (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // classic wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic                       wb_ack_o,
  output logic      [31:0]           wb_dat_o,
  // pins, asynchronous to clk_i
  input  wire logic                  ext_irq_pin_i,
  input  wire logic [7:0]            port_b_i,
  // peripheral units on clk_i
  input  wire logic [7:0]            timer_zero_count_i,
  input  wire logic [7:0]            periph_evt_a_i,
  input  wire logic [7:0]            periph_evt_b_i,
  // processor core
  input  wire mic_pkg::mic_core_in_t core_i,
  output mic_pkg::mic_core_out_t     core_o,
  output logic                       core_irq_o
);

  // byte address match, shared by write decode and read mux
  function automatic logic mic_hit(input logic [7:0] adr, input logic [7:0] off);
    mic_hit = (adr == off);
  endfunction : mic_hit

  // any flag with its enable set
  function automatic logic mic_any(input logic [7:0] flags, input logic [7:0] ens);
    mic_any = |(flags & ens);
  endfunction : mic_any

  // register state
  logic                     global_irq_enable;
  logic                     periph_group_enable;
  logic [2:0]               ctrl_enables;
  logic [7:0]               ctrl_flags;
  logic [7:0]               periph_flag_reg_a;
  logic [7:0]               periph_flag_reg_b;
  logic [7:0]               periph_enable_reg_a;
  logic [7:0]               periph_enable_reg_b;
  logic                     ext_edge_select;
  logic [7:0]               port_change_en;
  logic                     status_timeout;
  logic                     status_pwrdown;
  logic [7:0]               tmr_prev;
  mic_pkg::mic_wake_state_t wake_state;

  // derived signals
  logic [7:0]               irq_control_reg;
  logic [8:0]               pin_sync;
  logic [8:0]               pin_prev;
  logic                     wr_strobe;
  logic                     wr_ctrl;
  logic                     ext_edge;
  logic                     port_change;
  logic                     tmr_roll;
  logic [7:0]               ctrl_set;
  logic                     ctrl_pend;
  logic                     periph_pend;
  logic                     any_pend;
  logic                     enable_clearing;
  logic                     take_irq;
  logic [7:0]               rd_byte;

  // control register image as software sees it
  assign irq_control_reg = {global_irq_enable, periph_group_enable, ctrl_enables,
                            ctrl_flags[`MIC_CTRL_FLAG_HI:`MIC_CTRL_FLAG_LO]};

  // a write lands on the edge where the master sees ack, so it acts once only
  assign wr_strobe = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign wr_ctrl   = wr_strobe & mic_hit(wb_adr_i, `MIC_OFF_CTRL);

  // ack one cycle after the request, dropped the cycle after it was given
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
    end
  end

  // read mux; unmapped offsets and upper bits read as zero
  always_comb begin
    rd_byte = `MIC_RST_BYTE;
    case (1'b1)
      mic_hit(wb_adr_i, `MIC_OFF_CTRL):    rd_byte = irq_control_reg;
      mic_hit(wb_adr_i, `MIC_OFF_FLAG_A):  rd_byte = periph_flag_reg_a;
      mic_hit(wb_adr_i, `MIC_OFF_FLAG_B):  rd_byte = periph_flag_reg_b;
      mic_hit(wb_adr_i, `MIC_OFF_EN_A):    rd_byte = periph_enable_reg_a;
      mic_hit(wb_adr_i, `MIC_OFF_EN_B):    rd_byte = periph_enable_reg_b;
      mic_hit(wb_adr_i, `MIC_OFF_PORT_EN): rd_byte = port_change_en;
      mic_hit(wb_adr_i, `MIC_OFF_OPTION): rd_byte[`MIC_BIT_EDGE_SEL] = ext_edge_select;
      mic_hit(wb_adr_i, `MIC_OFF_STATUS): begin
        rd_byte[`MIC_BIT_TIMEOUT] = status_timeout;
        rd_byte[`MIC_BIT_PWRDOWN] = status_pwrdown;
      end
      default: rd_byte = `MIC_RST_BYTE;
    endcase
  end

  // read data captured with ack and held until the next answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= `MIC_WB_ZERO;
    end else if (wb_cyc_i & wb_stb_i & ~wb_ack_o) begin
      wb_dat_o <= {24'h00_0000, rd_byte};
    end
  end

  // individual and group enables, written by software only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      periph_group_enable <= 1'b0;
      ctrl_enables        <= 3'h0;
      periph_enable_reg_a <= `MIC_RST_BYTE;
      periph_enable_reg_b <= `MIC_RST_BYTE;
    end else begin
      if (wr_ctrl) begin
        periph_group_enable <= wb_dat_i[`MIC_BIT_GROUP_EN];
        ctrl_enables        <= wb_dat_i[`MIC_CTRL_EN_HI:`MIC_CTRL_EN_LO];
      end
      if (wr_strobe & mic_hit(wb_adr_i, `MIC_OFF_EN_A)) begin
        periph_enable_reg_a <= wb_dat_i[7:0] & `MIC_MASK_FLAG_A;
      end
      if (wr_strobe & mic_hit(wb_adr_i, `MIC_OFF_EN_B)) begin
        periph_enable_reg_b <= wb_dat_i[7:0] & `MIC_MASK_FLAG_B;
      end
    end
  end

  // edge select and per-pin change enables for port b
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_edge_select <= `MIC_RST_EDGE_SEL;
      port_change_en  <= `MIC_RST_BYTE;
    end else begin
      if (wr_strobe & mic_hit(wb_adr_i, `MIC_OFF_OPTION)) begin
        ext_edge_select <= wb_dat_i[`MIC_BIT_EDGE_SEL];
      end
      if (wr_strobe & mic_hit(wb_adr_i, `MIC_OFF_PORT_EN)) begin
        port_change_en <= wb_dat_i[7:0];
      end
    end
  end

  // pins pass two flops; one more stage of history gives the edge
  mic_pin_sync u_pin_sync (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pins_i ({ext_irq_pin_i, port_b_i}),
    .sync_o (pin_sync),
    .prev_o (pin_prev)
  );

  assign ext_edge = ext_edge_select ? (pin_sync[8] & ~pin_prev[8])
                                    : (~pin_sync[8] & pin_prev[8]);

  // a glitch shorter than a cycle may be missed; that is the pin's limit
  assign port_change = mic_any(pin_sync[7:0] ^ pin_prev[7:0], port_change_en);

  // timer count history to see the FFh to zero rollover
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmr_prev <= `MIC_TMR_ZERO;
    end else begin
      tmr_prev <= timer_zero_count_i;
    end
  end

  assign tmr_roll = (tmr_prev == `MIC_TMR_MAX) &&
                    (timer_zero_count_i == `MIC_TMR_ZERO);

  always_comb begin
    ctrl_set               = `MIC_RST_BYTE;
    ctrl_set[`MIC_BIT_T0F]  = tmr_roll;
    ctrl_set[`MIC_BIT_EXTF] = ext_edge;
    ctrl_set[`MIC_BIT_PCF]  = port_change;
  end

  // control flags: pin, port change and timer zero
  mic_flag_bank #(
    .IMPL_MASK (`MIC_MASK_CTRL_FLAG)
  ) u_flags_ctrl (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .set_i     (ctrl_set),
    .wr_i      (wr_ctrl),
    .wr_data_i (wb_dat_i[7:0]),
    .flags_o   (ctrl_flags)
  );

  // flag register a: converter, serial rx/tx, sync serial, capture one, timers
  mic_flag_bank #(
    .IMPL_MASK (`MIC_MASK_FLAG_A)
  ) u_flags_a (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .set_i     (periph_evt_a_i),
    .wr_i      (wr_strobe & mic_hit(wb_adr_i, `MIC_OFF_FLAG_A)),
    .wr_data_i (wb_dat_i[7:0]),
    .flags_o   (periph_flag_reg_a)
  );

  // flag register b: clock monitor, comparators, eeprom, low-power wake, capture two
  mic_flag_bank #(
    .IMPL_MASK (`MIC_MASK_FLAG_B)
  ) u_flags_b (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .set_i     (periph_evt_b_i),
    .wr_i      (wr_strobe & mic_hit(wb_adr_i, `MIC_OFF_FLAG_B)),
    .wr_data_i (wb_dat_i[7:0]),
    .flags_o   (periph_flag_reg_b)
  );

  // a flag left set by the routine is simply taken again
  assign ctrl_pend   = mic_any({5'h00, ctrl_flags[`MIC_CTRL_FLAG_HI:`MIC_CTRL_FLAG_LO]},
                               {5'h00, ctrl_enables});
  assign periph_pend = mic_any(periph_flag_reg_a, periph_enable_reg_a) |
                       mic_any(periph_flag_reg_b, periph_enable_reg_b);
  assign any_pend    = ctrl_pend | (periph_group_enable & periph_pend);

  // a write clearing the enable this cycle beats a take in the same cycle
  assign enable_clearing = wr_ctrl & ~wb_dat_i[`MIC_BIT_GLOBAL_EN];
  assign take_irq        = (wake_state == mic_pkg::MIC_RUN) & global_irq_enable &
                           any_pend & ~enable_clearing;

  // request level to the core, registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_irq_o <= 1'b0;
    end else begin
      core_irq_o <= global_irq_enable & any_pend;
    end
  end

  // global enable: take clears it, return sets it, software may write it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      global_irq_enable <= 1'b0;
    end else if (take_irq) begin
      global_irq_enable <= 1'b0;
    end else if (core_i.ret_irq) begin
      global_irq_enable <= 1'b1;
    end else if (wr_ctrl) begin
      global_irq_enable <= wb_dat_i[`MIC_BIT_GLOBAL_EN];
    end
  end

  // vector and push pulses; flag set plus this flop gives 3-4 cycles from a pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_o.push     <= 1'b0;
      core_o.pc_load  <= 1'b0;
      core_o.ret_addr <= `MIC_PC_ZERO;
      core_o.vector   <= `MIC_VECTOR;
      core_o.wake     <= 1'b0;
    end else begin
      core_o.push    <= take_irq;
      core_o.pc_load <= take_irq;
      core_o.wake    <= (wake_state == mic_pkg::MIC_ASLEEP) & any_pend;
      if (take_irq) begin
        core_o.ret_addr <= core_i.pc;
      end
    end
  end

  // wake needs an enabled flag, so a set flag always explains the wake
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_state <= mic_pkg::MIC_RUN;
    end else begin
      case (wake_state)
        mic_pkg::MIC_RUN: begin
          if (core_i.sleep & ~take_irq) begin
            wake_state <= mic_pkg::MIC_ASLEEP;
          end
        end
        mic_pkg::MIC_ASLEEP: begin
          if (any_pend) begin
            wake_state <= mic_pkg::MIC_WAKE;
          end
        end
        mic_pkg::MIC_WAKE: begin
          // core runs pc + 1 here; the vector may follow in run
          wake_state <= mic_pkg::MIC_RUN;
        end
        default: wake_state <= mic_pkg::MIC_RUN;
      endcase
    end
  end

  // status timeout and power-down bits; power control is not touched here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_timeout <= `MIC_RST_TIMEOUT;
      status_pwrdown <= `MIC_RST_PWRDOWN;
    end else if (((wake_state == mic_pkg::MIC_ASLEEP) & any_pend) |
                 ((wake_state == mic_pkg::MIC_RUN) & core_i.sleep & ~take_irq)) begin
      status_timeout <= 1'b1;
      status_pwrdown <= 1'b0;
    end
  end

endmodule : mic_irq_ctrl

`default_nettype wire

// >>> sim/mic_irq_monitor.sv
// port-level checks for the interrupt controller
`timescale 1ns/1ns
`default_nettype none
module mic_irq_monitor (
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  input wire logic                   wb_cyc_i,
  input wire logic                   wb_stb_i,
  input wire logic                   wb_ack_o,
  input wire logic [31:0]            wb_dat_o,
  input wire mic_pkg::mic_core_in_t  core_i,
  input wire mic_pkg::mic_core_out_t core_o,
  input wire logic                   core_irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // a request waiting for its answer, and an interrupt being taken
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_take;
    core_o.push && core_o.pc_load;
  endsequence
  property p_ack;
    s_req |=> wb_ack_o;
  endproperty
  property p_ack1;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  property p_hi;
    wb_ack_o |-> wb_dat_o[31:8] == 24'h000000;
  endproperty
  property p_pair;
    core_o.push == core_o.pc_load;
  endproperty
  property p_vec;
    s_take |-> core_o.vector == 13'h0004;
  endproperty
  property p_ret;
    s_take |-> core_o.ret_addr == $past(core_i.pc);
  endproperty
  // enable is gone by the cycle after the take, so the request drops
  property p_drop;
    s_take |=> !core_irq_o;
  endproperty
  property p_once;
    s_take |=> !core_o.push;
  endproperty
  property p_gate;
    s_take |-> core_irq_o;
  endproperty
  // pc + 1 runs before any vectoring
  property p_wake;
    core_o.wake |=> !core_o.wake && !core_o.push;
  endproperty
  a_ack: assert property (p_ack) else $error("request not acked next cycle");
  a_ack1: assert property (p_ack1) else $error("ack longer than one cycle");
  a_hi: assert property (p_hi) else $error("upper read data not zero");
  a_pair: assert property (p_pair) else $error("push and load apart");
  a_vec: assert property (p_vec) else $error("wrong vector");
  a_ret: assert property (p_ret) else $error("wrong return address");
  a_drop: assert property (p_drop) else $error("enable kept after take");
  a_once: assert property (p_once) else $error("take repeated");
  a_gate: assert property (p_gate) else $error("take without request");
  a_wake: assert property (p_wake) else $error("vector before pc + 1");
endmodule : mic_irq_monitor
`default_nettype wire

// >>> sim/mic_core_model.sv
// behavioural core: program counter, sleep and return strobes
`timescale 1ns/1ns
`default_nettype none
module mic_core_model (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   ret_req_i,
  input  wire logic                   sleep_req_i,
  input  wire mic_pkg::mic_core_out_t co_i,
  output var  mic_pkg::mic_core_in_t  ci_o
);
  // pc advances each cycle, stands while asleep
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ci_o <= '0;
    end else begin
      ci_o.ret_irq <= ret_req_i;
      if (co_i.pc_load) begin
        ci_o.pc <= co_i.vector;
      end else if (!ci_o.sleep || co_i.wake) begin
        ci_o.pc <= ci_o.pc + 13'h0001;
      end
      // sleep held until the wake pulse is seen
      if (co_i.wake) begin
        ci_o.sleep <= 1'b0;
      end else if (sleep_req_i) begin
        ci_o.sleep <= 1'b1;
      end
    end
  end
endmodule : mic_core_model
`default_nettype wire

// >>> sim/mic_irq_ctrl_tb.sv
// self-checking bench for the interrupt controller
`timescale 1ns/1ns
`default_nettype none
bind mic_irq_ctrl mic_irq_monitor u_mon (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .core_i(core_i), .core_o(core_o),
  .core_irq_o(core_irq_o)
);
module mic_irq_ctrl_tb;
  logic                   clk_i = 1'b0;
  logic                   rst_i, cyc, stb, we, ack, pin, irq, ret_req, slp_req;
  logic [7:0]             adr, pb, tmr, ea, eb, q;
  logic [3:0]             sel;
  logic [31:0]            dw, dr;
  mic_pkg::mic_core_in_t  ci;
  mic_pkg::mic_core_out_t co;
  int                     err_total = 0, checked = 0, n, i;
  logic [7:0]             ra [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10,
                                     8'h14, 8'h18, 8'h1C, 8'h20};
  logic [7:0]             rv [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                     8'h40, 8'h00, 8'h18, 8'h00};
  always #5 clk_i = ~clk_i;
  mic_irq_ctrl u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_ack_o(ack), .wb_dat_o(dr),
    .ext_irq_pin_i(pin), .port_b_i(pb), .timer_zero_count_i(tmr), .periph_evt_a_i(ea),
    .periph_evt_b_i(eb), .core_i(ci), .core_o(co), .core_irq_o(irq)
  );
  mic_core_model u_core (
    .clk_i(clk_i), .rst_i(rst_i), .ret_req_i(ret_req), .sleep_req_i(slp_req),
    .co_i(co), .ci_o(ci)
  );
  task automatic complete_run;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one classic cycle; read data taken at the acking edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    q = dr[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
    if (k == 20) begin
      err_total++;
      complete_run();
    end
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(q, e);
  endtask : rd
  // bounded wait for wake or push; n ends at lim if none came
  task automatic wt(input logic wk, input int lim);
    n = 0;
    while ((wk ? co.wake : co.push) !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
  endtask : wt
  task automatic pa(input logic [7:0] v);
    ea <= v;
    @(posedge clk_i);
    ea <= 8'h00;
  endtask : pa
  // return instruction; a few cycles for the enable to land
  task automatic rt;
    ret_req <= 1'b1;
    @(posedge clk_i);
    ret_req <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : rt
  task automatic nap;
    slp_req <= 1'b1;
    @(posedge clk_i);
    slp_req <= 1'b0;
    repeat (3) @(posedge clk_i);
    pa(8'h01);
    wt(1'b1, 10);
    chk(8'(n < 10), 8'h01);
  endtask : nap
  initial begin
    {cyc, stb, we, pin, ret_req, slp_req} = '0;
    {adr, pb, tmr, ea, eb} = '0;
    sel = 4'hF;
    dw = '0;
    rst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // status is read-only, unmapped space swallows writes
    wb(1'b1, 8'h1C, 8'h00);
    wb(1'b1, 8'h20, 8'hFF);
    for (i = 0; i < 9; i++) begin
      rd(ra[i], rv[i]);
    end
    // flags set with every enable clear
    ea <= 8'hFF;
    eb <= 8'hFF;
    @(posedge clk_i);
    ea <= 8'h00;
    eb <= 8'h00;
    rd(8'h04, 8'h7F);
    rd(8'h08, 8'hFD);
    chk(8'(irq), 8'h00);
    wb(1'b1, 8'h04, 8'h00);
    wb(1'b1, 8'h08, 8'h00);
    rd(8'h04, 8'h00);
    // timer rollover, then port b change on enabled pin only
    tmr <= 8'hFF;
    @(posedge clk_i);
    tmr <= 8'h00;
    @(posedge clk_i);
    rd(8'h00, 8'h04);
    wb(1'b1, 8'h00, 8'h00);
    wb(1'b1, 8'h18, 8'h01);
    pb <= 8'h02;
    repeat (4) @(posedge clk_i);
    rd(8'h00, 8'h00);
    pb <= 8'h03;
    repeat (4) @(posedge clk_i);
    rd(8'h00, 8'h01);
    // pin rising then falling edge, taken in four or five cycles
    wb(1'b1, 8'h00, 8'h90);
    pin <= 1'b1;
    wt(1'b0, 10);
    chk(8'(n > 3 && n < 6), 8'h01);
    rd(8'h00, 8'h12);
    wb(1'b1, 8'h00, 8'h10);
    rt();
    rd(8'h00, 8'h90);
    wb(1'b1, 8'h14, 8'h00);
    pin <= 1'b0;
    wt(1'b0, 10);
    chk(8'(n > 3 && n < 6), 8'h01);
    // peripheral requests need the group enable and their own bit
    wb(1'b1, 8'h00, 8'h00);
    wb(1'b1, 8'h0C, 8'h01);
    wb(1'b1, 8'h00, 8'h80);
    pa(8'h03);
    wt(1'b0, 8);
    chk(8'(n), 8'h08);
    wb(1'b1, 8'h00, 8'hC0);
    wt(1'b0, 8);
    chk(8'(n < 8), 8'h01);
    rd(8'h04, 8'h03);
    wb(1'b1, 8'h04, 8'h00);
    pa(8'h02);
    rt();
    wt(1'b0, 8);
    chk(8'(n), 8'h08);
    wb(1'b1, 8'h04, 8'h00);
    // request arriving as the enable is written off stays pending
    ea <= 8'h01;
    fork
      wb(1'b1, 8'h00, 8'h40);
      begin
        @(posedge clk_i);
        ea <= 8'h00;
      end
    join
    wt(1'b0, 8);
    chk(8'(n), 8'h08);
    wb(1'b1, 8'h00, 8'hC0);
    wt(1'b0, 8);
    chk(8'(n < 8), 8'h01);
    // wake from sleep, without then with the global enable
    wb(1'b1, 8'h04, 8'h00);
    wb(1'b1, 8'h00, 8'h40);
    nap();
    wt(1'b0, 6);
    chk(8'(n), 8'h06);
    rd(8'h1C, 8'h10);
    rd(8'h04, 8'h01);
    wb(1'b1, 8'h04, 8'h00);
    wb(1'b1, 8'h00, 8'hC0);
    nap();
    wt(1'b0, 6);
    chk(8'(n < 6), 8'h01);
    complete_run();
  end
endmodule : mic_irq_ctrl_tb
`default_nettype wire
